/* File: pkg/iec_pkg.sv */
// Package: register map, field layout and carriers of the interrupt control
package iec_pkg;

	// -------------------------------------------------------------------
	// Register map (byte addresses on the APB)
	// -------------------------------------------------------------------
	localparam int         ADDR_W   = 8;
	localparam logic [7:0] OFS_EDGE = 8'h00;
	localparam logic [7:0] OFS_EN1  = 8'h04;
	localparam logic [7:0] OFS_EN2  = 8'h08;
	localparam logic [7:0] OFS_FLAG = 8'h0C;

	// -------------------------------------------------------------------
	// Widths and reset values
	// -------------------------------------------------------------------
	localparam int         EXT_N        = 5;
	localparam int         WKP_N        = 8;
	localparam int         CH_N         = 8;
	localparam logic [4:0] RST_EDGE_SEL = 5'h00;
	localparam logic [2:0] EDGE_RSV     = 3'h7;
	localparam logic [7:0] RST_EN       = 8'h00;
	localparam logic [4:0] RST_FLAG     = 5'h00;
	localparam logic [1:0] ARM_FULL     = 2'h3;

	// -------------------------------------------------------------------
	// Bit positions in the enable registers
	// -------------------------------------------------------------------
	localparam int EN1_TA  = 7;
	localparam int EN1_RSV = 6;
	localparam int EN1_WP  = 5;
	localparam int EN2_DT  = 7;
	localparam int EN2_AD  = 6;
	localparam int EN2_RSV = 5;
	localparam int EN2_TG  = 4;
	localparam int EN2_FH  = 3;
	localparam int EN2_FL  = 2;

	// -------------------------------------------------------------------
	// Edge channels: 0..4 external pins, then the three shared pins
	// -------------------------------------------------------------------
	localparam int CH_ADC_TRIGGER_PIN = 5;
	localparam int CH_TMF   = 6;
	localparam int CH_TMC   = 7;
	localparam int SEL_ADC_TRIGGER_PIN = 4;
	localparam int SEL_TMF   = 3;
	localparam int SEL_TMC   = 1;

	// Request flags raised by the peripherals themselves
	typedef struct packed {
		logic       timer_a;
		logic [7:0] wakeup;
		logic       dxfer;
		logic       adc;
		logic       timer_g;
		logic       timer_fh;
		logic       timer_fl;
	} iec_src_t;

	// Gated requests towards the CPU
	typedef struct packed {
		logic [4:0] ext;
		logic       wakeup;
		logic       timer_a;
		logic       dxfer;
		logic       adc;
		logic       timer_g;
		logic       timer_fh;
		logic       timer_fl;
	} iec_req_t;

	// Edge pulses handed to the shared peripherals
	typedef struct packed {
		logic adc_trigger;
		logic timer_f;
		logic timer_c;
	} iec_evt_t;

endpackage

/* File: logic/iec_edge_det.sv */
// Synchronised edge detector with selectable polarity
`timescale 1ns/1ps
module iec_edge_det (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic ce,
	input  wire logic pin,
	input  wire logic rise_sel,
	output logic      edge_hit
);

	logic       sync1;
	logic       sync2;
	logic       prev;
	logic [1:0] fill;
	logic       armed;
	logic       rose;
	logic       fell;

	// -------------------------------------------------------------------
	// Synchroniser, history and warm-up counter
	// -------------------------------------------------------------------
	// The warm-up stops a pin that idles high from faking an edge
	// out of reset, at the price of three blind cycles.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			prev  <= 1'b0;
			fill  <= 2'h0;
		end else if (ce) begin
			sync1 <= pin;
			sync2 <= sync1;
			prev  <= sync2;
			if (!armed)
				fill <= fill + 2'h1;
		end
	end

	// Polarity select: 1 catches rising, 0 falling
	assign armed    = (fill == iec_pkg::ARM_FULL);
	assign rose     = sync2 & ~prev;
	assign fell     = ~sync2 & prev;
	assign edge_hit = armed & (rise_sel ? rose : fell);

endmodule

/* File: logic/iec_ctrl.sv */
// Interrupt edge select, enable registers and request gating, APB slave
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// - edge_sel_4 picks falling (0) or rising (1) on ext pin 4 and ADC trigger.
// - edge_sel_3 picks edge for ext pin 3 and timer F event input.
// - edge_sel_2 picks falling (0) or rising (1) on ext pin 2.
// - edge_sel_1 picks edge for ext pin 1 and timer C event input.
// - edge_sel_0 picks falling (0) or rising (1) on ext pin 0; resets 0.
// - Both enable registers are 8-bit read/write and reset to zero.
// - Enable one bit 7 gates timer A overflow requests.
// - Enable one bit 6 is spare, read/write, resets to zero.
// - Enable one bit 5 gates requests from all eight wakeup pins.
// - Enable one bits 4..0 gate the matching external pin requests.
// - Enable two bit 7 gates direct transfer requests.
// - Enable two bit 6 gates A/D converter requests.
// - Enable two bit 5 is spare, read/write, resets to zero.
// - Enable two bit 4 gates timer G capture and overflow requests.
// - Enable two bit 3 gates timer FH compare and overflow requests.
// - Enable two bit 2 gates timer FL compare and overflow requests.
// - External flag sets on the selected edge when the pin is an interrupt.
// - Top three edge select bits read as one and ignore writes.
module iec_ctrl (
	input  wire logic                          clk,
	input  wire logic                          resetn,
	input  wire logic                          ce,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [iec_pkg::ADDR_W-1:0]    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic [iec_pkg::EXT_N-1:0]     ext_int_pin,
	input  wire logic [iec_pkg::EXT_N-1:0]     ext_int_func,
	input  wire logic                          adc_trigger_pin,
	input  wire logic                          timer_f_event_input,
	input  wire logic                          timer_c_event_input,
	input  wire iec_pkg::iec_src_t             src_flag,
	output iec_pkg::iec_req_t                  irq_req,
	output iec_pkg::iec_evt_t                  edge_evt,
	output logic      [iec_pkg::EXT_N-1:0]     ext_int_flag
);

	// -------------------------------------------------------------------
	// Register state
	// -------------------------------------------------------------------
	logic [4:0]                irq_edge_select;
	logic [7:0]                interrupt_enable_one;
	logic [7:0]                interrupt_enable_two;

	// -------------------------------------------------------------------
	// Bus decode
	// -------------------------------------------------------------------
	logic                      access;
	logic                      done;
	logic                      wr_done;
	logic                      rd_done;
	logic                      hit_edge;
	logic                      hit_en1;
	logic                      hit_en2;
	logic                      hit_flag;
	logic                      mapped;
	logic [31:0]               rd_mux;
	logic                      next_pready;

	// Access phase; the answer comes one cycle into it
	assign access      = psel & penable;
	assign done        = access & pready;
	assign wr_done     = done & pwrite & ce;
	assign rd_done     = done & ~pwrite & ce;
	assign next_pready = access & ~pready;
	assign hit_edge    = (paddr == iec_pkg::OFS_EDGE);
	assign hit_en1     = (paddr == iec_pkg::OFS_EN1);
	assign hit_en2     = (paddr == iec_pkg::OFS_EN2);
	assign hit_flag    = (paddr == iec_pkg::OFS_FLAG);
	assign mapped      = hit_edge | hit_en1 | hit_en2 | hit_flag;

	// Read mux; the spare edge bits are forced high
	assign rd_mux =
		hit_edge ? {24'h000000, iec_pkg::EDGE_RSV, irq_edge_select} :
		hit_en1  ? {24'h000000, interrupt_enable_one} :
		hit_en2  ? {24'h000000, interrupt_enable_two} :
		hit_flag ? {27'h0000000, ext_int_flag} :
		32'h00000000;

	// -------------------------------------------------------------------
	// APB answer
	// -------------------------------------------------------------------
	// Ready, error and read data are all registered so the bus outputs
	// come straight from flip-flops; costs one wait state per access.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (ce) begin
			pready  <= next_pready;
			pslverr <= next_pready & ~mapped;
			if (next_pready && !pwrite)
				prdata <= rd_mux;
		end
	end

	// -------------------------------------------------------------------
	// Edge select and enable registers
	// -------------------------------------------------------------------
	// Only the low five edge bits are storage; the top three are
	// constants, so writes to them fall away.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq_edge_select      <= iec_pkg::RST_EDGE_SEL;
			interrupt_enable_one <= iec_pkg::RST_EN;
			interrupt_enable_two <= iec_pkg::RST_EN;
		end else if (wr_done) begin
			if (hit_edge)
				irq_edge_select <= pwdata[4:0];
			if (hit_en1)
				interrupt_enable_one <= pwdata[7:0];
			if (hit_en2)
				interrupt_enable_two <= pwdata[7:0];
		end
	end

	// -------------------------------------------------------------------
	// Edge detection on the pins
	// -------------------------------------------------------------------
	logic [iec_pkg::CH_N-1:0]  ch_pin;
	logic [iec_pkg::CH_N-1:0]  ch_rise;
	logic [iec_pkg::CH_N-1:0]  ch_hit;

	// Shared pins follow the edge bit of their partner pin
	assign ch_pin  = {timer_c_event_input, timer_f_event_input,
	                  adc_trigger_pin, ext_int_pin};
	assign ch_rise = {irq_edge_select[iec_pkg::SEL_TMC],
	                  irq_edge_select[iec_pkg::SEL_TMF],
	                  irq_edge_select[iec_pkg::SEL_ADC_TRIGGER_PIN],
	                  irq_edge_select};

	// One synchronised detector per channel
	genvar gi;
	generate
		for (gi = 0; gi < iec_pkg::CH_N; gi++) begin : g_ch
			iec_edge_det u_det (
				.clk      (clk),
				.resetn   (resetn),
				.ce       (ce),
				.pin      (ch_pin[gi]),
				.rise_sel (ch_rise[gi]),
				.edge_hit (ch_hit[gi])
			);
		end
	endgenerate

	// -------------------------------------------------------------------
	// External request flags
	// -------------------------------------------------------------------
	logic [iec_pkg::EXT_N-1:0] ext_set;
	logic [iec_pkg::EXT_N-1:0] ext_keep;
	logic [iec_pkg::EXT_N-1:0] next_ext_flag;
	logic                      wr_flag;

	// An edge landing in the clearing cycle still sets the flag
	assign wr_flag       = wr_done & hit_flag;
	assign ext_set       = ch_hit[iec_pkg::EXT_N-1:0] & ext_int_func;
	assign ext_keep      = wr_flag ? pwdata[iec_pkg::EXT_N-1:0] : 5'h1F;
	assign next_ext_flag = (ext_int_flag & ext_keep) | ext_set;

	always_ff @(posedge clk) begin
		if (!resetn)
			ext_int_flag <= iec_pkg::RST_FLAG;
		else if (ce)
			ext_int_flag <= next_ext_flag;
	end

	// -------------------------------------------------------------------
	// Request gating and event pulses
	// -------------------------------------------------------------------
	iec_pkg::iec_req_t         next_req;
	iec_pkg::iec_evt_t         next_evt;

	// Each source needs both its flag and its enable
	assign next_req.ext      = ext_int_flag &
	                           interrupt_enable_one[4:0];
	assign next_req.wakeup   = (|src_flag.wakeup) &
	                           interrupt_enable_one[iec_pkg::EN1_WP];
	assign next_req.timer_a  = src_flag.timer_a &
	                           interrupt_enable_one[iec_pkg::EN1_TA];
	assign next_req.dxfer    = src_flag.dxfer &
	                           interrupt_enable_two[iec_pkg::EN2_DT];
	assign next_req.adc      = src_flag.adc &
	                           interrupt_enable_two[iec_pkg::EN2_AD];
	assign next_req.timer_g  = src_flag.timer_g &
	                           interrupt_enable_two[iec_pkg::EN2_TG];
	assign next_req.timer_fh = src_flag.timer_fh &
	                           interrupt_enable_two[iec_pkg::EN2_FH];
	assign next_req.timer_fl = src_flag.timer_fl &
	                           interrupt_enable_two[iec_pkg::EN2_FL];

	// Shared-pin edges are handed on, not latched here
	assign next_evt.adc_trigger = ch_hit[iec_pkg::CH_ADC_TRIGGER_PIN];
	assign next_evt.timer_f     = ch_hit[iec_pkg::CH_TMF];
	assign next_evt.timer_c     = ch_hit[iec_pkg::CH_TMC];

	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq_req  <= '0;
			edge_evt <= '0;
		end else if (ce) begin
			irq_req  <= next_req;
			edge_evt <= next_evt;
		end
	end

	// -------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------
	sequence s_wr(logic [7:0] ofs);
		psel && penable && pready && pwrite && ce && paddr == ofs;
	endsequence

	sequence s_rd(logic [7:0] ofs);
		psel && penable && pready && !pwrite && ce && paddr == ofs;
	endsequence

	property p_sel_rst;
		@(posedge clk) disable iff (!resetn)
		$rose(resetn) |-> irq_edge_select == 5'h00;
	endproperty
	a_sel_rst: assert property (p_sel_rst)
		else $error("edge select not cleared by reset");

	property p_en_rst;
		@(posedge clk) disable iff (!resetn)
		$rose(resetn) |-> interrupt_enable_one == 8'h00 &&
			interrupt_enable_two == 8'h00;
	endproperty
	a_en_rst: assert property (p_en_rst)
		else $error("enable registers not cleared by reset");

	property p_sel_wr;
		@(posedge clk) disable iff (!resetn)
		s_wr(iec_pkg::OFS_EDGE) |=>
			irq_edge_select == $past(pwdata[4:0]);
	endproperty
	a_sel_wr: assert property (p_sel_wr)
		else $error("edge select write lost");

	property p_rsv_rd;
		@(posedge clk) disable iff (!resetn)
		(access && !pready && !pwrite && ce && paddr == iec_pkg::OFS_EDGE)
			|=> prdata[7:5] == 3'h7 ##0 s_rd(iec_pkg::OFS_EDGE);
	endproperty
	a_rsv_rd: assert property (p_rsv_rd)
		else $error("edge select spare bits not read as one");

	property p_rsv1;
		@(posedge clk) disable iff (!resetn)
		s_wr(iec_pkg::OFS_EN1) |=>
			interrupt_enable_one[6] == $past(pwdata[6]);
	endproperty
	a_rsv1: assert property (p_rsv1)
		else $error("spare enable one bit not stored");

	property p_rsv2;
		@(posedge clk) disable iff (!resetn)
		s_wr(iec_pkg::OFS_EN2) |=>
			interrupt_enable_two[5] == $past(pwdata[5]);
	endproperty
	a_rsv2: assert property (p_rsv2)
		else $error("spare enable two bit not stored");

	property p_flag_set;
		@(posedge clk) disable iff (!resetn)
		(ce && |ext_set) |=>
			(ext_int_flag & $past(ext_set)) == $past(ext_set);
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("selected edge did not set its flag");

	property p_flag_hold;
		@(posedge clk) disable iff (!resetn)
		(ce && !wr_flag) |=>
			($past(ext_int_flag) & ~ext_int_flag) == 5'h00;
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("flag dropped without a clearing write");

	property p_ext_req;
		@(posedge clk) disable iff (!resetn)
		ce |=> irq_req.ext ==
			($past(ext_int_flag) & $past(interrupt_enable_one[4:0]));
	endproperty
	a_ext_req: assert property (p_ext_req)
		else $error("external request not flag and enable");

	property p_ta_req;
		@(posedge clk) disable iff (!resetn)
		(ce && !interrupt_enable_one[7]) ##1 ce |-> !irq_req.timer_a;
	endproperty
	a_ta_req: assert property (p_ta_req)
		else $error("timer A request passed while disabled");

	property p_ready;
		@(posedge clk) disable iff (!resetn)
		(access && !pready && ce) |=> pready;
	endproperty
	a_ready: assert property (p_ready)
		else $error("access phase not answered in one cycle");

	// Wakeup group: any of the eight flags, gated by one enable bit
	property p_wk_req;
		@(posedge clk) disable iff (!resetn)
		ce |=> irq_req.wakeup == ($past(|src_flag.wakeup) &
			$past(interrupt_enable_one[iec_pkg::EN1_WP]));
	endproperty
	a_wk_req: assert property (p_wk_req)
		else $error("wakeup request not flag and enable");

	// Sources of enable two, gathered in bit order for one compare
	property p_en2;
		@(posedge clk) disable iff (!resetn)
		ce |=> {irq_req.dxfer, irq_req.adc, irq_req.timer_g,
			irq_req.timer_fh, irq_req.timer_fl} ==
			($past({src_flag.dxfer, src_flag.adc, src_flag.timer_g,
			src_flag.timer_fh, src_flag.timer_fl}) &
			$past({interrupt_enable_two[iec_pkg::EN2_DT],
			interrupt_enable_two[iec_pkg::EN2_AD],
			interrupt_enable_two[iec_pkg::EN2_TG],
			interrupt_enable_two[iec_pkg::EN2_FH],
			interrupt_enable_two[iec_pkg::EN2_FL]}));
	endproperty
	a_en2: assert property (p_en2)
		else $error("enable two request not flag and enable");

	// Registers move only under a write to their own place; an
	// unmapped write must leave every one of them alone
	property p_reg_hold;
		@(posedge clk) disable iff (!resetn)
		!(wr_done && (hit_edge || hit_en1 || hit_en2)) |=>
			$stable(irq_edge_select) &&
			$stable(interrupt_enable_one) &&
			$stable(interrupt_enable_two);
	endproperty
	a_reg_hold: assert property (p_reg_hold)
		else $error("register changed without a write");

	// Unmapped places answer with an error, mapped ones without
	property p_err;
		@(posedge clk) disable iff (!resetn)
		(access && !pready && ce) |=> pslverr == !$past(mapped);
	endproperty
	a_err: assert property (p_err)
		else $error("error answer does not match the address");

endmodule

/* File: bench/iec_src_model.sv */
// Partner model: peripheral request flags and the accepting CPU
`timescale 1ns/1ps
module iec_src_model (
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire iec_pkg::iec_src_t set_req,
	input  wire iec_pkg::iec_src_t clr_req,
	input  wire iec_pkg::iec_req_t irq_req,
	output iec_pkg::iec_src_t      src_flag
);
	// ------------------------------------------------------------
	// Flag storage
	// ------------------------------------------------------------
	logic taken;

	// Set beats clear; only software clears, acceptance never does
	always_ff @(posedge clk) begin
		if (!resetn) begin
			src_flag <= '0;
			taken    <= 1'h0;
		end else begin
			src_flag <= (src_flag & ~clr_req) | set_req;
			taken    <= |irq_req; // Accepted, flag left as is
		end
	end
endmodule

/* File: bench/irq_edge_and_enable_control_tb.sv */
// Self-checking bench of the interrupt edge and enable control
`timescale 1ns/1ps
module irq_edge_and_enable_control_tb;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic              clk, resetn, ce, psel, penable, pwrite;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata, seed, e1, e2, r;
	logic              pready, pslverr, adc_p, tf_p, tc_p, v;
	logic [4:0]        pins, func, xflag, oh;
	logic [11:0]       ev_cnt, eev, xe;
	logic              look_on;
	logic [32:0]       exp_rd[$];
	logic [32:0]       exp_ob[$];
	int                failures, comparisons, cyc;
	iec_pkg::iec_src_t set_req, clr_req, src_flag, sv;
	iec_pkg::iec_req_t irq_req, rq;
	iec_pkg::iec_evt_t edge_evt;

	iec_ctrl u_dut (.clk(clk), .resetn(resetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_int_pin(pins), .ext_int_func(func),
		.adc_trigger_pin(adc_p), .timer_f_event_input(tf_p),
		.timer_c_event_input(tc_p), .src_flag(src_flag),
		.irq_req(irq_req), .edge_evt(edge_evt), .ext_int_flag(xflag));

	iec_src_model u_src (.clk(clk), .resetn(resetn), .set_req(set_req),
		.clr_req(clr_req), .irq_req(irq_req), .src_flag(src_flag));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task report_and_stop();
		// A note never matched means a result never appeared
		if (exp_rd.size() != 0 || exp_ob.size() != 0)
			failures++;
		if (failures == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task chk(input logic [32:0] got, input logic [32:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// APB transfer; waits for pready without assuming a latency
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel   <= 1'h1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		// Read before the edge's updates: the value sampled at this edge
		do
			@(posedge clk);
		while (pready !== 1'h1);
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask

	task rd(input logic [7:0] a, input logic [32:0] exp);
		exp_rd.push_back(exp);
		apb(1'h0, a, 32'h0);
	endtask

	task look(input logic [32:0] exp);
		exp_ob.push_back(exp);
		@(posedge clk) look_on <= 1'h1;
		@(posedge clk) look_on <= 1'h0;
	endtask

	// Move every edge pin to one level, then let the pipeline settle
	task lv(input logic l);
		@(posedge clk) pins <= {5{l}};
		adc_p <= l;
		tf_p  <= l;
		tc_p  <= l;
		repeat (6) @(posedge clk);
	endtask

	// ------------------------------------------------------------
	// Clock, timeout and output watcher
	// ------------------------------------------------------------
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	// Ceiling far above the roughly seven hundred cycles of the run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			report_and_stop();
		end
	end

	// Oldest note is matched against each result as it appears
	always @(posedge clk) begin
		if (pready === 1'h1 && pwrite === 1'h0) begin
			if (exp_rd.size() == 0) failures++;
			else chk({pslverr, prdata}, exp_rd.pop_front());
		end
		if (look_on === 1'h1) begin
			if (exp_ob.size() == 0) failures++;
			else chk({4'h0, xflag, irq_req, ev_cnt}, exp_ob.pop_front());
		end
		if (!resetn) ev_cnt <= 12'h000;
		else ev_cnt <= ev_cnt + {3'h0, edge_evt[2], 3'h0, edge_evt[1],
			3'h0, edge_evt[0]};
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{resetn, psel, penable, pwrite, look_on} = 5'h00;
		{adc_p, tf_p, tc_p} = 3'h0;
		{paddr, pwdata, pins, func} = 50'h0;
		{set_req, clr_req} = '0;
		ce = 1'h1;
		seed = 32'h37B28358;
		eev = 12'h000;
		repeat (10) @(posedge clk);
		resetn <= 1'h1;
		// Reset values and the fixed upper edge bits
		rd(iec_pkg::OFS_EDGE, 33'h0E0);
		rd(iec_pkg::OFS_EN1, 33'h000);
		rd(iec_pkg::OFS_EN2, 33'h000);
		apb(1'h1, iec_pkg::OFS_EDGE, 32'h00);
		rd(iec_pkg::OFS_EDGE, 33'h0E0);
		apb(1'h1, iec_pkg::OFS_EDGE, 32'hFF);
		rd(iec_pkg::OFS_EDGE, 33'h0FF);
		// Unmapped place: error answer, write has no effect
		apb(1'h1, 8'h10, 32'hFF);
		rd(8'h10, 33'h100000000);
		// Random enables against random peripheral flags
		for (int i = 0; i < 8; i++) begin
			e1 = xs();
			e2 = xs();
			r = xs();
			sv = r[13:0];
			apb(1'h1, iec_pkg::OFS_EN1, e1);
			apb(1'h1, iec_pkg::OFS_EN2, e2);
			rd(iec_pkg::OFS_EN1, {25'h0, e1[7:0]});
			rd(iec_pkg::OFS_EN2, {25'h0, e2[7:0]});
			rq = '0;
			rq.wakeup = (|sv.wakeup) & e1[5];
			rq.timer_a = sv.timer_a & e1[7];
			rq.dxfer = sv.dxfer & e2[7];
			rq.adc = sv.adc & e2[6];
			rq.timer_g = sv.timer_g & e2[4];
			rq.timer_fh = sv.timer_fh & e2[3];
			rq.timer_fl = sv.timer_fl & e2[2];
			@(posedge clk) set_req <= sv;
			@(posedge clk) set_req <= '0;
			repeat (3) @(posedge clk);
			look({9'h000, rq, 12'h000});
			@(posedge clk) clr_req <= '1;
			@(posedge clk) clr_req <= '0;
		end
		// Edge polarity per pin; only the pin set as interrupt counts
		for (int s = 0; s < 2; s++) begin
			v = s[0];
			apb(1'h1, iec_pkg::OFS_EDGE, v ? 32'h1F : 32'h00);
			for (int n = 0; n < 5; n++) begin
				oh = 5'h01 << n;
				func <= oh;
				apb(1'h1, iec_pkg::OFS_EN1, {27'h0, oh});
				lv(~v);
				look({21'h0, eev});
				lv(v);
				eev = eev + 12'h111;
				look({4'h0, oh, oh, 7'h00, eev});
				apb(1'h1, iec_pkg::OFS_FLAG, 32'hFF);
				rd(iec_pkg::OFS_FLAG, {28'h0, oh});
				apb(1'h1, iec_pkg::OFS_FLAG, 32'h00);
			end
		end
		// One select bit at a time: each shared pin follows its own bit
		func <= 5'h00;
		for (int b = 0; b < 3; b++) begin
			oh = (b == 0) ? 5'h10 : (b == 1) ? 5'h08 : 5'h02;
			xe = (b == 0) ? 12'h100 : (b == 1) ? 12'h010 : 12'h001;
			apb(1'h1, iec_pkg::OFS_EDGE, {27'h0, oh});
			lv(1'h0);
			eev = eev + 12'h111 - xe;
			look({21'h0, eev});
			lv(1'h1);
			eev = eev + xe;
			look({21'h0, eev});
		end
		// Frozen clock enable: pins move, nothing reacts until it returns
		func <= 5'h1F;
		ce   <= 1'h0;
		lv(1'h0);
		look({21'h0, eev});
		ce <= 1'h1;
		repeat (6) @(posedge clk);
		eev = eev + 12'h110;
		look({4'h0, 5'h1D, 5'h10, 7'h00, eev});
		repeat (3) @(posedge clk);
		report_and_stop();
	end
endmodule
